// [hw/spx_stack_exec.sv]
// Purpose: executes double pop, shadow pop/push, file and register push
// Assumes: data memory answers reads with mem_rvalid, takes writes at once
// Notes: working registers and status live here; shadow set is internal
`timescale 1ns/1ns
`include "spx_regs.svh"

module spx_stack_exec
	import spx_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        instr_valid,
	input  wire logic [23:0] instr_word,
	output logic             busy,
	output logic             done,
	output logic             illegal,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [15:0]      reg_rdata,
	output logic [15:0]      mem_addr,
	output logic [15:0]      mem_wdata,
	output logic             mem_we,
	output logic             mem_re,
	input  wire logic [15:0] mem_rdata,
	input  wire logic        mem_rvalid
);

	spx_state_t  state_r;
	logic [3:0]  pair_r;
	logic        busy_r;
	logic        done_r;
	logic        illegal_r;
	logic [15:0] rdata_r;
	logic [15:0] maddr_r;
	logic [15:0] mwdata_r;
	logic        mwe_r;
	logic        mre_r;
	logic [15:0] wreg_r [16];
	logic [15:0] stat_r;
	logic [15:0] shadow_w_r [4];
	logic [15:0] shadow_stat_r;

	logic        idle;
	logic        go;
	logic        dec_popd;
	logic        dec_pops;
	logic        dec_pushs;
	logic        dec_pushf;
	logic        dec_pushw;
	logic        push_direct;
	logic [2:0]  src_mode;
	logic [3:0]  src_idx;
	logic [3:0]  off_idx;
	logic [3:0]  dst_pair;
	logic [15:0] sp;
	logic [15:0] sp_dec;
	logic [15:0] sp_inc;
	logic [15:0] src_val;
	logic [15:0] src_ea;
	logic [15:0] src_upd;
	logic        src_wb;
	logic [15:0] file_addr;
	logic        sw_wr_wreg;

	assign idle      = (state_r == ST_IDLE);
	assign go        = idle && instr_valid;
	// fixed patterns; masks free the pair, file address, source and offset fields
	assign dec_popd  = ((instr_word & `SPX_POPD_MASK) == `SPX_POPD_CODE);
	assign dec_pops  = (instr_word == `SPX_POPS_CODE);
	assign dec_pushs = (instr_word == `SPX_PUSHS_CODE);
	assign dec_pushf = ((instr_word & `SPX_PUSHF_MASK) == `SPX_PUSHF_CODE);
	assign dec_pushw = ((instr_word & `SPX_PUSHW_MASK) == `SPX_PUSHW_CODE);

	// low bit of the pair field is forced to zero, so odd bases cannot occur
	assign dst_pair  = {instr_word[10:8], 1'b0};
	assign src_mode  = instr_word[6:4];
	assign src_idx   = instr_word[3:0];
	assign off_idx   = {instr_word[18:16], 1'b0};
	// word address only; 16 bits cover every even location up to 65534
	assign file_addr = {instr_word[15:1], 1'b0};

	assign sp        = wreg_r[`SPX_SP_IDX];
	assign sp_dec    = sp - `SPX_STEP;
	assign sp_inc    = sp + `SPX_STEP;
	assign src_val   = wreg_r[src_idx];
	assign push_direct = (src_mode == `SPX_MODE_DIR);
	assign sw_wr_wreg  = reg_wr && !busy_r && !reg_addr[4];

	// source operand address and pointer update, as the word move does
	always_comb begin
		src_ea  = src_val;
		src_upd = src_val;
		src_wb  = 1'b0;
		unique case (src_mode)
			`SPX_MODE_DIR, `SPX_MODE_IND: begin
				src_ea = src_val;
			end
			`SPX_MODE_POSTD: begin
				src_upd = src_val - `SPX_STEP;
				src_wb  = 1'b1;
			end
			`SPX_MODE_POSTI: begin
				src_upd = src_val + `SPX_STEP;
				src_wb  = 1'b1;
			end
			`SPX_MODE_PRED: begin
				src_ea  = src_val - `SPX_STEP;
				src_upd = src_ea;
				src_wb  = 1'b1;
			end
			`SPX_MODE_PREI: begin
				src_ea  = src_val + `SPX_STEP;
				src_upd = src_ea;
				src_wb  = 1'b1;
			end
			default: begin
				src_ea = src_val + wreg_r[off_idx];
			end
		endcase
	end

	// sequencer: double pop waits for two reads, memory pushes for one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			pair_r  <= 4'h0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (go && dec_popd) begin
						state_r <= ST_POP_ODD;
						pair_r  <= dst_pair;
					end else if (go && (dec_pushf || (dec_pushw && !push_direct))) begin
						state_r <= ST_PUSH_RD;
					end
				end
				ST_POP_ODD: begin
					if (mem_rvalid) begin
						state_r <= ST_POP_EVEN;
					end
				end
				ST_POP_EVEN: begin
					if (mem_rvalid) begin
						state_r <= ST_IDLE;
					end
				end
				ST_PUSH_RD: begin
					// a slow peripheral read simply holds us here longer
					if (mem_rvalid) begin
						state_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// status pulses and busy level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_r    <= 1'b0;
			done_r    <= 1'b0;
			illegal_r <= 1'b0;
		end else begin
			done_r    <= 1'b0;
			illegal_r <= 1'b0;
			if (go) begin
				if (dec_popd || dec_pushf || (dec_pushw && !push_direct)) begin
					busy_r <= 1'b1;
				end else if (dec_pops || dec_pushs || dec_pushw) begin
					done_r <= 1'b1;
				end else begin
					illegal_r <= 1'b1;
				end
			end else if (!idle && mem_rvalid && state_r != ST_POP_ODD) begin
				busy_r <= 1'b0;
				done_r <= 1'b1;
			end
		end
	end

	// memory port: word-wide only, there are no byte lanes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			maddr_r  <= 16'h0000;
			mwdata_r <= 16'h0000;
			mwe_r    <= 1'b0;
			mre_r    <= 1'b0;
		end else begin
			mwe_r <= 1'b0;
			mre_r <= 1'b0;
			if (go && dec_popd) begin
				maddr_r <= sp_dec;
				mre_r   <= 1'b1;
			end else if (go && dec_pushf) begin
				maddr_r <= file_addr;
				mre_r   <= 1'b1;
			end else if (go && dec_pushw && push_direct) begin
				maddr_r  <= sp;
				mwdata_r <= src_val;
				mwe_r    <= 1'b1;
			end else if (go && dec_pushw) begin
				maddr_r <= src_ea;
				mre_r   <= 1'b1;
			end else if (state_r == ST_POP_ODD && mem_rvalid) begin
				maddr_r <= sp_dec;
				mre_r   <= 1'b1;
			end else if (state_r == ST_PUSH_RD && mem_rvalid) begin
				maddr_r  <= sp;
				mwdata_r <= mem_rdata;
				mwe_r    <= 1'b1;
			end
		end
	end

	// working registers; instruction effects override a same-cycle bus write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 16; i++) begin
				wreg_r[i] <= `SPX_WREG_RST;
			end
		end else begin
			if (sw_wr_wreg) begin
				wreg_r[reg_addr[3:0]] <= reg_wdata;
			end
			if (go && dec_popd) begin
				wreg_r[`SPX_SP_IDX] <= sp_dec;
			end
			if (go && dec_pops) begin
				for (int i = 0; i < 4; i++) begin
					wreg_r[i] <= shadow_w_r[i];
				end
			end
			if (go && dec_pushw && src_wb) begin
				wreg_r[src_idx] <= src_upd;
			end
			if (go && dec_pushw && push_direct) begin
				wreg_r[`SPX_SP_IDX] <= sp_inc;
			end
			if (state_r == ST_POP_ODD && mem_rvalid) begin
				wreg_r[pair_r + 4'h1] <= mem_rdata;
				wreg_r[`SPX_SP_IDX]   <= sp_dec;
			end
			if (state_r == ST_POP_EVEN && mem_rvalid) begin
				wreg_r[pair_r] <= mem_rdata;
			end
			if (state_r == ST_PUSH_RD && mem_rvalid) begin
				wreg_r[`SPX_SP_IDX] <= sp_inc;
			end
		end
	end

	// status flags: only the five arithmetic flags are shadowed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_r <= `SPX_STAT_RST;
		end else if (go && dec_pops) begin
			stat_r <= (stat_r & ~`SPX_FLAG_MASK) | (shadow_stat_r & `SPX_FLAG_MASK);
		end else if (reg_wr && !busy_r && reg_addr == `SPX_STAT_ADDR) begin
			stat_r <= reg_wdata;
		end
	end

	// single shadow level: each push replaces it, a pop only reads it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				shadow_w_r[i] <= `SPX_WREG_RST;
			end
			shadow_stat_r <= `SPX_STAT_RST;
		end else if (go && dec_pushs) begin
			for (int i = 0; i < 4; i++) begin
				shadow_w_r[i] <= wreg_r[i];
			end
			shadow_stat_r <= stat_r & `SPX_FLAG_MASK;
		end
	end

	// bus reads: shadow set is deliberately not mapped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 16'h0000;
		end else if (reg_rd) begin
			if (!reg_addr[4]) begin
				rdata_r <= wreg_r[reg_addr[3:0]];
			end else if (reg_addr == `SPX_STAT_ADDR) begin
				rdata_r <= stat_r;
			end else begin
				rdata_r <= 16'h0000;
			end
		end else begin
			rdata_r <= 16'h0000;
		end
	end

	assign busy      = busy_r;
	assign done      = done_r;
	assign illegal   = illegal_r;
	assign reg_rdata = rdata_r;
	assign mem_addr  = maddr_r;
	assign mem_wdata = mwdata_r;
	assign mem_we    = mwe_r;
	assign mem_re    = mre_r;

endmodule : spx_stack_exec

// [include/spx_regs.svh]
// Purpose: constants for the stack push/pop execution block
// Assumes: 24-bit instruction words, 16-bit data words
// Notes: opcode patterns, field masks and reset values
`ifndef SPX_REGS_SVH
`define SPX_REGS_SVH
`define SPX_POPD_MASK   24'hFFF8FF
`define SPX_POPD_CODE   24'hBE004F
`define SPX_POPS_CODE   24'hFE8000
`define SPX_PUSHS_CODE  24'hFEA000
`define SPX_PUSHF_MASK  24'hFF0001
`define SPX_PUSHF_CODE  24'hF80000
`define SPX_PUSHW_MASK  24'hF8FF80
`define SPX_PUSHW_CODE  24'h781F80
`define SPX_STEP        16'h0002
`define SPX_SP_IDX      4'hF
`define SPX_STAT_ADDR   5'h10
`define SPX_WREG_RST    16'h0000
`define SPX_STAT_RST    16'h0000
`define SPX_FLAG_MASK   16'h010F
`define SPX_MODE_DIR    3'h0
`define SPX_MODE_IND    3'h1
`define SPX_MODE_POSTD  3'h2
`define SPX_MODE_POSTI  3'h3
`define SPX_MODE_PRED   3'h4
`define SPX_MODE_PREI   3'h5
`endif

// [include/spx_pkg.sv]
// Purpose: shared types for the stack push/pop execution block
// Assumes: nothing beyond the constants header
// Notes: sequencer states only
package spx_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_POP_ODD,
		ST_POP_EVEN,
		ST_PUSH_RD
	} spx_state_t;
endpackage : spx_pkg

// [sim/spx_mem_model.sv]
// Purpose: data memory partner holding the software stack
// Assumes: byte addresses, word access, 256 words aliased
// Notes: lat adds wait cycles before a read answer
`timescale 1ns/1ns
module spx_mem_model (
	input  wire logic        clk,
	input  wire logic [3:0]  lat,
	input  wire logic [15:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	input  wire logic        mem_we,
	input  wire logic        mem_re,
	output logic [15:0]      mem_rdata,
	output logic             mem_rvalid
);
	logic [15:0] ram [0:255];
	logic [15:0] hold_r = 16'h0000;
	logic [3:0]  wait_r = 4'h0;
	initial mem_rvalid = 1'b0;
	initial mem_rdata = 16'h0000;
	always @(posedge clk) begin
		mem_rvalid <= 1'b0;
		// released bus toggles so stale data never matches by luck
		mem_rdata <= ~mem_rdata;
		if (mem_we)
			ram[mem_addr[8:1]] <= mem_wdata;
		if (mem_re && lat == 4'h0) begin
			mem_rvalid <= 1'b1;
			mem_rdata <= ram[mem_addr[8:1]];
		end else if (mem_re) begin
			wait_r <= lat;
			hold_r <= ram[mem_addr[8:1]];
		end else if (wait_r != 4'h0) begin
			wait_r <= wait_r - 4'h1;
			if (wait_r == 4'h1) begin
				mem_rvalid <= 1'b1;
				mem_rdata <= hold_r;
			end
		end
	end
endmodule : spx_mem_model

// [sim/spx_stack_exec_asserts.sv]
// Purpose: port checks for spx_stack_exec
// Assumes: memory answers at least one cycle after a read
// Notes: opcode patterns come from the constants header
`timescale 1ns/1ns
`include "spx_regs.svh"
module spx_stack_exec_chk (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        instr_valid,
	input wire logic [23:0] instr_word,
	input wire logic        busy,
	input wire logic        done,
	input wire logic        illegal,
	input wire logic [15:0] mem_addr,
	input wire logic        mem_we,
	input wire logic        mem_re
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	wire acc   = instr_valid && !busy;
	wire popd  = acc && (instr_word & `SPX_POPD_MASK) == `SPX_POPD_CODE;
	wire pushf = acc && (instr_word & `SPX_PUSHF_MASK) == `SPX_PUSHF_CODE;
	wire pushw = acc && (instr_word & `SPX_PUSHW_MASK) == `SPX_PUSHW_CODE
		&& instr_word[6:4] == `SPX_MODE_DIR;
	wire shad  = acc && (instr_word == `SPX_POPS_CODE || instr_word == `SPX_PUSHS_CODE);
	a_shadow_one_cycle: assert property (shad |=> done && !busy && !mem_re && !mem_we)
		else $error("shadow op not single cycle");
	a_popd_start: assert property (popd |=> busy && mem_re && !done)
		else $error("double pop did not start a read");
	a_popd_span: assert property (popd |=> !done [*4])
		else $error("double pop finished too early");
	a_pushf_addr: assert property (pushf |=> mem_re && mem_addr == $past(instr_word[15:0]))
		else $error("file push read wrong address");
	a_pushw_direct: assert property (pushw |=> mem_we && done)
		else $error("register push not written at once");
	a_write_done: assert property (mem_we |-> done && !busy)
		else $error("stack write outside completion");
	a_busy_end: assert property ($fell(busy) |-> done)
		else $error("busy fell without done");
	a_illegal_quiet: assert property (illegal |-> !done && !mem_we && !busy)
		else $error("illegal word had an effect");
	a_read_aligned: assert property (mem_re |-> !mem_addr[0])
		else $error("odd memory read address");
endmodule : spx_stack_exec_chk
bind spx_stack_exec spx_stack_exec_chk u_chk (
	.clk         (clk),
	.rst_n       (rst_n),
	.instr_valid (instr_valid),
	.instr_word  (instr_word),
	.busy        (busy),
	.done        (done),
	.illegal     (illegal),
	.mem_addr    (mem_addr),
	.mem_we      (mem_we),
	.mem_re      (mem_re)
);

// [sim/tb_top.sv]
// Purpose: self-checking bench for spx_stack_exec
// Assumes: stack pointer kept even, pair bases even
// Notes: memory preloaded and inspected inside the model
`timescale 1ns/1ns
`include "spx_regs.svh"
module tb_top;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        instr_valid = 1'b0;
	logic [23:0] instr_word = 24'h000000;
	logic        reg_wr = 1'b0, reg_rd = 1'b0;
	logic        busy, done, illegal, mem_we, mem_re, mem_rvalid;
	logic [4:0]  reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata, mem_addr, mem_wdata, mem_rdata;
	logic [3:0]  lat = 4'h0;
	int          error_cnt = 0;
	int          checks_done = 0;
	always #10 clk = ~clk;
	spx_stack_exec u_dut (
		.clk         (clk),
		.rst_n       (rst_n),
		.instr_valid (instr_valid),
		.instr_word  (instr_word),
		.busy        (busy),
		.done        (done),
		.illegal     (illegal),
		.reg_addr    (reg_addr),
		.reg_wdata   (reg_wdata),
		.reg_wr      (reg_wr),
		.reg_rd      (reg_rd),
		.reg_rdata   (reg_rdata),
		.mem_addr    (mem_addr),
		.mem_wdata   (mem_wdata),
		.mem_we      (mem_we),
		.mem_re      (mem_re),
		.mem_rdata   (mem_rdata),
		.mem_rvalid  (mem_rvalid)
	);
	spx_mem_model u_mem (
		.clk        (clk),
		.lat        (lat),
		.mem_addr   (mem_addr),
		.mem_wdata  (mem_wdata),
		.mem_we     (mem_we),
		.mem_re     (mem_re),
		.mem_rdata  (mem_rdata),
		.mem_rvalid (mem_rvalid)
	);
	task automatic end_of_test();
		if (error_cnt == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", reg_rdata, e);
	endtask : rd
	task automatic ex(input logic [23:0] w, input logic bad = 1'b0);
		int n;
		n = 0;
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_word <= w;
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
		while (done !== 1'b1 && illegal !== 1'b1 && n < 50) begin
			n++;
			@(posedge clk);
			#1;
		end
		chk("illegal", 16'(illegal), 16'(bad));
		// memory takes the stack write one edge after the design issues it
		@(posedge clk);
		#1;
		if (n >= 50) begin
			// a hung sequencer ends the run here
			error_cnt++;
			end_of_test();
		end
	endtask : ex
	task automatic t_popd();
		for (int i = 0; i < 3; i++) begin
			logic [4:0] n;
			n = 5'(i * 6);
			lat = 4'(i);
			wr(5'h0F, 16'h0054);
			u_mem.ram[8'h29] = 16'hA000 + 16'(i);
			u_mem.ram[8'h28] = 16'hB000 + 16'(i);
			ex(`SPX_POPD_CODE | {13'h0000, n[3:1], 8'h00});
			rd(n + 5'h01, 16'hA000 + 16'(i));
			rd(n, 16'hB000 + 16'(i));
			rd(5'h0F, 16'h0050);
		end
	endtask : t_popd
	task automatic t_shadow();
		for (int k = 0; k < 4; k++)
			wr(5'(k), 16'h1111);
		ex(`SPX_PUSHS_CODE);
		for (int k = 0; k < 4; k++)
			wr(5'(k), 16'h2000 + 16'(k));
		wr(5'h10, 16'h01F5);
		ex(`SPX_PUSHS_CODE);
		for (int p = 0; p < 2; p++) begin
			// clobber every restored register so a missed copy shows
			for (int k = 0; k < 4; k++)
				wr(5'(k), 16'h0000);
			wr(5'h10, 16'h00EA);
			ex(`SPX_POPS_CODE);
			for (int k = 0; k < 4; k++)
				rd(5'(k), 16'h2000 + 16'(k));
			rd(5'h10, 16'h01E5);
		end
	endtask : t_shadow
	task automatic t_push();
		lat = 4'h2;
		wr(5'h0F, 16'h0060);
		u_mem.ram[8'hFF] = 16'h5A5A;
		ex(24'hF8FFFE);
		chk("stack", u_mem.ram[8'h30], 16'h5A5A);
		rd(5'h0F, 16'h0062);
		wr(5'h02, 16'h6889);
		ex(24'h781F82);
		chk("stack", u_mem.ram[8'h31], 16'h6889);
		wr(5'h05, 16'h0040);
		wr(5'h0A, 16'h0004);
		u_mem.ram[8'h22] = 16'hB20A;
		ex(24'h7D1FE5);
		chk("stack", u_mem.ram[8'h32], 16'hB20A);
		rd(5'h0F, 16'h0066);
		ex(24'h000000, 1'b1);
		rd(5'h0F, 16'h0066);
		wr(5'h11, 16'hFFFF);
		rd(5'h11, 16'h0000);
	endtask : t_push
	task automatic t_modes();
		logic [15:0] ea, wb;
		for (int g = 1; g < 6; g++) begin
			ea = (g == 4) ? 16'h000E : (g == 5) ? 16'h0012 : 16'h0010;
			wb = (g == 2 || g == 4) ? 16'h000E : (g == 1) ? 16'h0010 : 16'h0012;
			wr(5'h04, 16'h0010);
			wr(5'h0F, 16'h0070);
			u_mem.ram[ea[8:1]] = 16'hD000 + ea;
			u_mem.ram[8'h38] = 16'h0000;
			ex({16'h781F, 1'b1, 3'(g), 4'h4});
			chk("stack", u_mem.ram[8'h38], 16'hD000 + ea);
			rd(5'h04, wb);
			rd(5'h0F, 16'h0072);
		end
	endtask : t_modes
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(5'h0F, 16'h0000);
		t_popd();
		t_shadow();
		t_push();
		t_modes();
		end_of_test();
	end
endmodule : tb_top
